// File: src/sbmu_unit.v
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Requesters always set header-present; headerless messages are not expected.
// (R2) Opcode 0..6: write rows, write half rows, read rows, read halves, atomics.
// (R3) Per-slot offsets ignored unless per-slot bit set; then added to global offset.
// (R4) Requesters keep per-slot bit zero on atomic messages.
// (R5) Completion bit on reads is forwarded to snoopers; otherwise unused.
// (R6) Single layout uses handle 0; dual layout sends dwords 7:4 to handle 1.
// (R7) Dual layout applies the one global offset to both entries.
// (R8) Global offset counts rows, half rows or dwords by message kind.
// (R9) Requesters keep global offset within 1023 rows or 2047 halves/dwords.
// (R10) Handles are buffer offsets in 512-bit units.
// (R11) End-of-thread only from geometry-pipeline threads, never on reads/atomics.
// (R12) Low 8 mask bits gate written or returned dwords; atomics ignore mask.
// (R13) Reads outside the allocated region return zero.
// (R14) Writes outside the allocated region are dropped.
// (R15) Rows/halves use per-slot offsets and width 1 or 2; atomics width 1.
// (R16) No state is kept between requests.
// (R17) Writes carry data after the header and return nothing.
// (R18) Reads are header only and always return writeback.
// (R19) Four-by-two variants carry per-slot offsets in their single phase.
// (R20) Cull-enabled tessellation writes raise a cull notice to the hull stage.
// (R21) Access is row granular, a row being 256 bits.
// (R22) No direct host read path exists.
// (R23) Opcode 7 does nothing and returns nothing.
`include "sbmu_defs.vh"
module sbmu_unit (
  input wire clk_sys,
  input wire rst,
  input wire req_valid,
  output wire req_ready,
  input wire [19:0] req_desc,
  input wire [15:0] req_handle0,
  input wire [15:0] req_handle1,
  input wire [31:0] req_slot0_ofs,
  input wire [31:0] req_slot1_ofs,
  input wire [7:0] req_exec_mask,
  input wire [7:0] req_cull_enable,
  input wire req_cull_positive,
  input wire [255:0] req_data,
  input wire [15:0] alloc_limit,
  output wire resp_valid,
  input wire resp_ready,
  output wire [255:0] resp_data,
  output reg snoop_complete_reg,
  output reg [15:0] snoop_handle_reg,
  output reg hull_cull_reg,
  output reg [15:0] hull_cull_handle_reg
);
  localparam ST_IDLE = 1'b0;
  localparam ST_READ = 1'b1;
  localparam DW_AW = `SBMU_RAM_AW + `SBMU_ROW_SHIFT;
  localparam DW_DEPTH = `SBMU_DEPTH_ROWS * `SBMU_ROW_DWORDS;

  // ****************************************
  // Opcode classes.
  // ****************************************
  function op_is_row;
    input [2:0] op;
    begin
      op_is_row = (op == `SBMU_OP_WRITE_ROWS) || (op == `SBMU_OP_READ_ROWS);
    end
  endfunction

  function op_is_half;
    input [2:0] op;
    begin
      op_is_half = (op == `SBMU_OP_WRITE_HALF_ROWS) || (op == `SBMU_OP_READ_HALF_ROWS);
    end
  endfunction

  function op_is_write;
    input [2:0] op;
    begin
      op_is_write = (op == `SBMU_OP_WRITE_ROWS) || (op == `SBMU_OP_WRITE_HALF_ROWS);
    end
  endfunction

  function op_is_read;
    input [2:0] op;
    begin
      op_is_read = (op == `SBMU_OP_READ_ROWS) || (op == `SBMU_OP_READ_HALF_ROWS);
    end
  endfunction

  function op_is_atomic;
    input [2:0] op;
    begin
      op_is_atomic = (op == `SBMU_OP_ATOMIC_MOVE) || (op == `SBMU_OP_ATOMIC_INCREMENT)
        || (op == `SBMU_OP_ATOMIC_ADD);
    end
  endfunction

  // ****************************************
  // Decode.
  // ****************************************
  wire [2:0] opc = req_desc[`SBMU_DESC_OPC_HI:`SBMU_DESC_OPC_LO]; // (R2)
  wire dual = req_desc[`SBMU_DESC_SWZ_BIT];
  wire pso = req_desc[`SBMU_DESC_PSO_BIT];
  wire [10:0] gofs = req_desc[`SBMU_DESC_GOFS_HI:`SBMU_DESC_GOFS_LO];
  // Opcode 7 falls in no class, so it neither stores nor answers.
  wire is_write = op_is_write(opc); // (R2) (R23)
  wire is_read = op_is_read(opc); // (R2) (R23)
  wire is_atomic = op_is_atomic(opc); // (R2) (R23)
  wire is_half = op_is_half(opc);

  // Dword address of slot n: handle in 16-dword units plus scaled offset.
  function [`SBMU_DW_ADDR_W-1:0] dw_addr;
    input [15:0] handle;
    input [31:0] slot_ofs;
    input [10:0] g;
    input use_slot;
    input [2:0] op;
    reg [31:0] eff;
    reg [`SBMU_DW_ADDR_W-1:0] base;
    begin
      eff = {{21{1'b0}}, g} + (use_slot ? slot_ofs : 32'h00000000); // (R3) (R7) (R19)
      base = {handle, 4'h0}; // (R10)
      if (op_is_row(op)) begin
        dw_addr = base + ({3'h0, eff[16:0]} << `SBMU_ROW_SHIFT); // (R8) (R21)
      end else if (op_is_half(op)) begin
        dw_addr = base + ({2'h0, eff[17:0]} << `SBMU_HALF_SHIFT); // (R8)
      end else begin
        dw_addr = base + eff[19:0]; // (R8)
      end
    end
  endfunction

  wire slot_ok = pso && !is_atomic; // (R15)
  wire [`SBMU_DW_ADDR_W-1:0] a0 = dw_addr(req_handle0, req_slot0_ofs, gofs, slot_ok, opc);
  wire [`SBMU_DW_ADDR_W-1:0] a1 = dw_addr(req_handle1, req_slot1_ofs, gofs, slot_ok, opc);
  wire [`SBMU_DW_ADDR_W-1:0] lim = {alloc_limit, 4'h0};

  // ****************************************
  // Storage, one dword per word across all rows.
  // ****************************************
  reg [31:0] mem [0:DW_DEPTH-1];
  reg state_reg;
  reg [255:0] rd_reg;
  wire fifo_in_ready;
  reg fifo_in_valid;
  wire [`SBMU_ROW_DWORDS*`SBMU_DW_ADDR_W-1:0] lane_addr_bus;
  wire [`SBMU_ROW_DWORDS-1:0] lane_wr;
  wire [`SBMU_ROW_DWORDS-1:0] lane_rd;
  integer wk;
  integer rk;

  // Dword i goes to entry 1 in dual layout for i in 7:4, else entry 0.
  function [`SBMU_DW_ADDR_W-1:0] lane_addr;
    input integer i;
    input [`SBMU_DW_ADDR_W-1:0] b0;
    input [`SBMU_DW_ADDR_W-1:0] b1;
    input d;
    input h;
    reg [31:0] iv;
    begin
      iv = i;
      if (d && iv[2]) begin
        lane_addr = b1 + {{(`SBMU_DW_ADDR_W-2){1'b0}}, iv[1:0]}; // (R6)
      end else if (h && !d) begin
        lane_addr = b0 + {{(`SBMU_DW_ADDR_W-2){1'b0}}, iv[1:0]};
      end else begin
        lane_addr = b0 + {{(`SBMU_DW_ADDR_W-3){1'b0}}, iv[2:0]}; // (R6)
      end
    end
  endfunction

  assign req_ready = (state_reg == ST_IDLE);
  wire take = req_valid && req_ready;

  genvar g_i;
  generate
    for (g_i = 0; g_i < `SBMU_ROW_DWORDS; g_i = g_i + 1) begin : g_lane
      wire [`SBMU_DW_ADDR_W-1:0] la = lane_addr(g_i, a0, a1, dual, is_half);
      wire in_rng = (la < lim) && (la < DW_DEPTH); // (R13) (R14)
      wire half_lane = !is_half || dual || (g_i < `SBMU_HALF_DWORDS);
      assign lane_addr_bus[g_i*`SBMU_DW_ADDR_W +: `SBMU_DW_ADDR_W] = la;
      assign lane_wr[g_i] = take && is_write && req_exec_mask[g_i]
        && in_rng && half_lane; // (R12) (R14)
      assign lane_rd[g_i] = req_exec_mask[g_i] && in_rng && half_lane; // (R12) (R13)
    end
  endgenerate

  // ****************************************
  // Atomics: one dword at handle 0 plus global offset, mask ignored.
  // ****************************************
  wire atom_in_rng = (a0 < lim) && (a0 < DW_DEPTH); // (R14)
  wire atom_en = take && is_atomic && atom_in_rng; // (R12) (R15)
  wire [31:0] atom_old = mem[a0[DW_AW-1:0]];
  reg [31:0] atom_new;

  always @* begin
    case (opc)
      `SBMU_OP_ATOMIC_MOVE: atom_new = req_data[31:0];
      `SBMU_OP_ATOMIC_INCREMENT: atom_new = atom_old + `SBMU_ONE_DW;
      `SBMU_OP_ATOMIC_ADD: atom_new = atom_old + req_data[31:0];
      default: atom_new = atom_old;
    endcase
  end

  // ****************************************
  // Store port: all lanes and the atomic unit write from one process.
  // ****************************************
  // Where both entries of a dual write meet one dword, the higher lane lands.
  always @(posedge clk_sys) begin
    for (wk = 0; wk < `SBMU_ROW_DWORDS; wk = wk + 1) begin
      if (lane_wr[wk]) begin
        mem[lane_addr_bus[wk*`SBMU_DW_ADDR_W +: DW_AW]] <= req_data[wk*32 +: 32]; // (R17)
      end
    end
    if (atom_en) begin
      mem[a0[DW_AW-1:0]] <= atom_new;
    end
  end

  // ****************************************
  // Read capture: masked or out-of-range lanes return zero.
  // ****************************************
  always @(posedge clk_sys) begin
    if (rst) begin
      rd_reg <= {`SBMU_ROW_BITS{1'b0}};
    end else if (take && is_read) begin
      for (rk = 0; rk < `SBMU_ROW_DWORDS; rk = rk + 1) begin
        rd_reg[rk*32 +: 32] <= lane_rd[rk]
          ? mem[lane_addr_bus[rk*`SBMU_DW_ADDR_W +: DW_AW]] : 32'h00000000; // (R13)
      end
    end
  end

  // ****************************************
  // Control: reads hold the port in ST_READ until the response is queued.
  // ****************************************
  always @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      snoop_complete_reg <= 1'b0;
      snoop_handle_reg <= 16'h0000;
      hull_cull_reg <= 1'b0;
      hull_cull_handle_reg <= 16'h0000;
    end else begin
      snoop_complete_reg <= take && is_read && req_desc[`SBMU_DESC_CMPL_BIT]; // (R5)
      snoop_handle_reg <= take ? req_handle0 : snoop_handle_reg;
      hull_cull_reg <= take && is_write && (req_cull_enable != 8'h00)
        && req_cull_positive; // (R20)
      hull_cull_handle_reg <= take ? req_handle0 : hull_cull_handle_reg;
      case (state_reg)
        ST_IDLE: begin
          if (take && is_read) begin // (R18)
            state_reg <= ST_READ;
          end
        end
        ST_READ: begin
          if (fifo_in_ready) begin
            state_reg <= ST_IDLE; // (R16)
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always @* begin
    fifo_in_valid = (state_reg == ST_READ);
  end

  // ****************************************
  // Writeback queue; a read meeting a full queue with resp_ready low waits in ST_READ, stalling new requests. Only messages read data. (R22)
  // ****************************************
  sbmu_fifo #(
    .WIDTH(`SBMU_ROW_BITS),
    .DEPTH(`SBMU_FIFO_DEPTH),
    .AW(`SBMU_FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(rd_reg),
    .out_valid(resp_valid),
    .out_ready(resp_ready),
    .out_data(resp_data)
  );
endmodule // sbmu_unit

// File: src/sbmu_defs.vh
`ifndef SBMU_DEFS_VH
`define SBMU_DEFS_VH

`define SBMU_DESC_HDR_BIT 19
`define SBMU_DESC_PSO_BIT 16
`define SBMU_DESC_CMPL_BIT 15
`define SBMU_DESC_SWZ_BIT 14
`define SBMU_DESC_GOFS_HI 13
`define SBMU_DESC_GOFS_LO 3
`define SBMU_DESC_OPC_HI 2
`define SBMU_DESC_OPC_LO 0

`define SBMU_OP_WRITE_ROWS 3'h0
`define SBMU_OP_WRITE_HALF_ROWS 3'h1
`define SBMU_OP_READ_ROWS 3'h2
`define SBMU_OP_READ_HALF_ROWS 3'h3
`define SBMU_OP_ATOMIC_MOVE 3'h4
`define SBMU_OP_ATOMIC_INCREMENT 3'h5
`define SBMU_OP_ATOMIC_ADD 3'h6
`define SBMU_OP_NONE 3'h7

`define SBMU_ROW_DWORDS 8
`define SBMU_ROW_BITS 256
`define SBMU_HALF_DWORDS 4
`define SBMU_ADDR_W 16
`define SBMU_DW_ADDR_W 20
`define SBMU_HANDLE_SHIFT 4
`define SBMU_ROW_SHIFT 3
`define SBMU_HALF_SHIFT 2
`define SBMU_DEPTH_ROWS 1024
`define SBMU_RAM_AW 10
`define SBMU_FIFO_DEPTH 4
`define SBMU_FIFO_AW 2
`define SBMU_CULL_HI 7
`define SBMU_CULL_LO 0
`define SBMU_ONE_DW 32'h00000001

`endif

// File: src/sbmu_fifo.v
`timescale 1ns/1ps
// ****************************************
// Small synchronous FIFO with valid/ready on both sides.
// ****************************************
module sbmu_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_sys,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;
  wire [AW-1:0] rd_ptr_next;

  assign in_ready = (count_reg != DEPTH[AW:0]) || out_ready;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;

  // Read data comes from a register that always shows the head entry.
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      if (push && ((count_reg == {(AW+1){1'b0}}) || (pop && count_reg == 1))) begin
        out_data <= in_data;
      end else begin
        out_data <= mem[rd_ptr_next];
      end
    end
  end
endmodule // sbmu_fifo

// File: dv/sbmu_monitor.sv
`timescale 1ns/1ps
// ****
// Port checker.
// ****
module sbmu_monitor (
  input wire clk_sys,
  input wire rst,
  input wire req_valid,
  input wire req_ready,
  input wire [19:0] req_desc,
  input wire [15:0] req_handle0,
  input wire [7:0] req_cull_enable,
  input wire req_cull_positive,
  input wire resp_valid,
  input wire resp_ready,
  input wire [255:0] resp_data,
  input wire snoop_complete_reg,
  input wire [15:0] snoop_handle_reg,
  input wire hull_cull_reg,
  input wire [15:0] hull_cull_handle_reg
);
  wire take = req_valid && req_ready;
  wire rd = take && req_desc[2:1] == 2'h1;
  wire cw = take && req_desc[2:1] == 2'h0 && req_cull_enable != 8'h00 && req_cull_positive;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_snoop_read: assert property (rd && req_desc[15] |=> snoop_complete_reg &&
    snoop_handle_reg == $past(req_handle0)) else $error("snoop missing");
  a_snoop_cause: assert property (snoop_complete_reg |-> $past(rd && req_desc[15]))
    else $error("stray snoop");
  a_cull_write: assert property (cw |=> hull_cull_reg &&
    hull_cull_handle_reg == $past(req_handle0)) else $error("cull missing");
  a_cull_cause: assert property (hull_cull_reg |-> $past(cw)) else $error("stray cull");
  a_write_quiet: assert property (take && !rd && !resp_valid |=> !resp_valid [*2])
    else $error("write answered");
  a_read_answer: assert property (rd && !resp_valid |-> ##2 resp_valid)
    else $error("read late");
  a_read_busy: assert property (rd |=> !req_ready) else $error("ready after read");
  a_resp_hold: assert property (resp_valid && !resp_ready |=> resp_valid &&
    $stable(resp_data)) else $error("answer dropped");
  a_ready_reset: assert property ($fell(rst) |-> req_ready) else $error("not ready");
endmodule // sbmu_monitor
bind sbmu_unit sbmu_monitor MON (.*);

// File: dv/sbmu_sink.sv
`timescale 1ns/1ps
// ****
// Writeback consumer that can stall.
// ****
module sbmu_sink (
  input wire clk_sys,
  input wire rst,
  input wire stall,
  output reg resp_ready = 1'b0
);
  always @(posedge clk_sys) begin
    resp_ready <= !rst && !stall;
  end
endmodule // sbmu_sink

// File: dv/tb_top.sv
`timescale 1ns/1ps
// ****
// Testbench.
// ****
module tb_top;
  reg clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, cpos = 1'b0, stall = 1'b0;
  reg [19:0] desc = 20'h0;
  reg [15:0] h0 = 16'h0, h1 = 16'h0, lim = 16'h0100;
  reg [31:0] s0 = 32'h0, s1 = 32'h0;
  reg [7:0] msk = 8'h0, cen = 8'h0;
  reg [255:0] dat = 256'h0, got;
  integer error_cnt = 0, n_tests = 0, cyc = 0, nsnp = 0, ncul = 0, i;
  localparam [255:0] A = {8{32'haaaa0001}}, B = {8{32'hbbbb0002}}, C = {B[255:128], A[127:0]};
  wire req_ready, resp_valid, resp_ready, snp, cul;
  wire [255:0] resp_data;
  sbmu_unit DUT (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_desc(desc), .req_handle0(h0), .req_handle1(h1), .req_slot0_ofs(s0),
    .req_slot1_ofs(s1), .req_exec_mask(msk), .req_cull_enable(cen), .req_cull_positive(cpos),
    .req_data(dat), .alloc_limit(lim), .resp_valid(resp_valid), .resp_ready(resp_ready),
    .resp_data(resp_data), .snoop_complete_reg(snp), .snoop_handle_reg(),
    .hull_cull_reg(cul), .hull_cull_handle_reg());
  sbmu_sink SNK (.clk_sys(clk_sys), .rst(rst), .stall(stall), .resp_ready(resp_ready));
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    nsnp = nsnp + (snp === 1'b1);
    ncul = ncul + (cul === 1'b1);
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
  end
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [8*6:1] nm, input [255:0] seen, input [255:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Flags are {per slot, complete, dual layout}; the header bit is always set.
  task send(input [2:0] op, input [15:0] a0, input [10:0] g, input [2:0] f,
    input [7:0] m, input [255:0] d);
    begin
      desc = {1'b1, 2'h0, f, g, op};
      h0 = a0;
      msk = m;
      dat = d;
      req_valid = 1'b1;
      while (req_ready !== 1'b1) begin
        @(posedge clk_sys);
        #1;
      end
      @(posedge clk_sys);
      #1 req_valid = 1'b0;
      @(posedge clk_sys);
      #1;
    end
  endtask
  task get;
    begin
      while (!(resp_valid === 1'b1 && resp_ready === 1'b1)) begin
        @(posedge clk_sys);
        #1;
      end
      got = resp_data;
      @(posedge clk_sys);
      #1;
    end
  endtask
  task rd(input [2:0] op, input [15:0] a0, input [10:0] g, input [255:0] e);
    begin
      send(op, a0, g, 3'h0, 8'hff, 256'h0);
      get;
      chk("read", got, e);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 rst = 1'b0;
    chk("ready", req_ready, 1'b1);
    chk("respv", resp_valid, 1'b0);
    $display("end reset");
    send(3'h0, 16'h2, 11'h2, 3'h0, 8'hff, A);
    send(3'h0, 16'h2, 11'h2, 3'h0, 8'h0f, B);
    rd(3'h2, 16'h3, 11'h0, {A[255:128], B[127:0]});
    $display("end rows");
    lim = 16'h0200;
    send(3'h0, 16'h100, 11'h1, 3'h0, 8'hff, B);
    lim = 16'h0100;
    send(3'h0, 16'hff, 11'h3, 3'h0, 8'hff, A);
    rd(3'h2, 16'hff, 11'h3, 256'h0);
    lim = 16'h0200;
    rd(3'h2, 16'h100, 11'h1, B);
    $display("end bounds");
    send(3'h0, 16'h8, 11'h1, 3'h0, 8'hff, 256'h0);
    h1 = 16'hc;
    send(3'h0, 16'h8, 11'h1, 3'h1, 8'hff, C);
    send(3'h2, 16'h8, 11'h1, 3'h1, 8'hff, 256'h0);
    get;
    chk("dual", got, C);
    h1 = 16'h0;
    rd(3'h2, 16'h8, 11'h1, {128'h0, C[127:0]});
    $display("end dual");
    s0 = 32'h2;
    send(3'h0, 16'h10, 11'h1, 3'h4, 8'hff, A);
    send(3'h0, 16'h10, 11'h1, 3'h0, 8'hff, B);
    rd(3'h2, 16'h10, 11'h3, A);
    rd(3'h2, 16'h10, 11'h1, B);
    s0 = 32'h0;
    $display("end slots");
    send(3'h0, 16'h18, 11'h0, 3'h0, 8'hff, 256'h0);
    send(3'h1, 16'h18, 11'h1, 3'h0, 8'hff, C);
    rd(3'h2, 16'h18, 11'h0, {C[127:0], 128'h0});
    send(3'h3, 16'h18, 11'h1, 3'h0, 8'hff, 256'h0);
    get;
    chk("half", got[127:0], C[127:0]);
    $display("end halves");
    send(3'h0, 16'h20, 11'h0, 3'h0, 8'hff, 256'h0);
    send(3'h4, 16'h20, 11'h5, 3'h0, 8'h00, {224'h0, 32'h10});
    send(3'h5, 16'h20, 11'h5, 3'h0, 8'h00, 256'h0);
    send(3'h6, 16'h20, 11'h5, 3'h0, 8'h00, {224'h0, 32'h3});
    send(3'h7, 16'h20, 11'h0, 3'h0, 8'hff, A);
    rd(3'h2, 16'h20, 11'h0, {64'h0, 32'h14, 160'h0});
    $display("end atomics");
    send(3'h2, 16'h20, 11'h0, 3'h2, 8'hff, 256'h0);
    get;
    send(3'h0, 16'h20, 11'h0, 3'h2, 8'hff, 256'h0);
    chk("snoop", nsnp, 1);
    cen = 8'h0f;
    cpos = 1'b1;
    send(3'h0, 16'h24, 11'h0, 3'h0, 8'hff, 256'h0);
    cen = 8'h00;
    send(3'h0, 16'h24, 11'h0, 3'h0, 8'hff, 256'h0);
    cpos = 1'b0;
    chk("cull", ncul, 1);
    $display("end notices");
    for (i = 0; i < 5; i = i + 1) send(3'h0, 16'h30, i[10:0], 3'h0, 8'hff, {8{i}});
    stall = 1'b1;
    for (i = 0; i < 5; i = i + 1) send(3'h2, 16'h30, i[10:0], 3'h0, 8'hff, 256'h0);
    repeat (3) @(posedge clk_sys);
    #1 chk("full", req_ready, 1'b0);
    stall = 1'b0;
    for (i = 0; i < 5; i = i + 1) begin
      get;
      chk("drain", got, {8{i}});
    end
    chk("empty", resp_valid, 1'b0);
    $display("end buffer");
    complete_run;
  end
endmodule // tb_top
